// ---- src/rfs_supervisor.sv ----
// rfs_supervisor: fault supervision for a dual-output multiphase regulator.
// assumes comparator flags arrive asynchronously from the analog front end and
// that the monitor voltage words come from a converter on core_clk_in.
`timescale 1ns/1ps
`default_nettype none
module rfs_supervisor #(
	parameter int unsigned IMB_CYC   = rfs_pkg::IMB_CYC,
	parameter int unsigned THERM_CYC = rfs_pkg::THERM_CYC
) (
	// clock and reset
	input  wire logic                                     core_clk_in,
	input  wire logic                                     rst_in,
	// system enables, asynchronous
	input  wire logic                                     enable_in,
	input  wire logic                                     supply_ok_in,
	// per-output comparator flags, asynchronous
	input  wire logic [rfs_pkg::NCH-1:0]                  oc_cmp_in,
	input  wire logic [rfs_pkg::NCH-1:0]                  severe_oc_cmp_in,
	input  wire logic [rfs_pkg::NCH-1:0]                  imbalance_cmp_in,
	input  wire logic [rfs_pkg::NCH-1:0]                  uv_cmp_in,
	input  wire logic [rfs_pkg::NCH-1:0]                  ov_cmp_in,
	input  wire logic [rfs_pkg::NCH-1:0]                  below_target_cmp_in,
	// temperature comparators, one of each per pin, asynchronous
	input  wire logic [rfs_pkg::NTEMP-1:0]                temp_trip_cmp_in,
	input  wire logic [rfs_pkg::NTEMP-1:0]                temp_above_reset_cmp_in,
	input  wire logic [rfs_pkg::NTEMP-1:0]                temp_shut_cmp_in,
	// monitor voltage words, synchronous
	input  wire logic [rfs_pkg::NCH-1:0][rfs_pkg::MON_W-1:0] monitor_mv_in,
	// thermal alert open-drain pin
	output logic                                          thermal_alert_n_out,
	output logic                                          thermal_alert_oe_out,
	// per-output power stage commands and the shared soft-start request
	output logic [rfs_pkg::NCH-1:0]                       output_ok_out,
	output logic [rfs_pkg::NCH-1:0]                       chan_tristate_out,
	output logic [rfs_pkg::NCH-1:0]                       low_side_on_out,
	output logic [rfs_pkg::NCH-1:0]                       shutdown_out,
	output logic                                          soft_start_out,
	// fault status
	output logic [rfs_pkg::NCH-1:0]                       overcurrent_fault_out,
	output logic [rfs_pkg::NCH-1:0]                       severe_overcurrent_out,
	output logic [rfs_pkg::NCH-1:0]                       imbalance_fault_out,
	output logic [rfs_pkg::NCH-1:0]                       uv_fault_out,
	output logic [rfs_pkg::NCH-1:0]                       ov_fault_out,
	output logic                                          thermal_fault_out,
	// telemetry
	output logic [rfs_pkg::NCH-1:0][rfs_pkg::PCT_W-1:0]   load_pct_out
);
	import rfs_pkg::*;

	// last count of each timer, and the thermal counter's ceiling, cut to the counter width
	localparam logic [OC_W-1:0]    OC_LAST    = OC_W'(OC_CYC - 1);
	localparam logic [IMB_W-1:0]   IMB_LAST   = IMB_W'(IMB_CYC - 1);
	localparam logic [THERM_W-1:0] THERM_LAST = THERM_W'(THERM_CYC - 1);
	localparam logic [THERM_W-1:0] THERM_TOP  = THERM_W'(THERM_CYC);

	logic [SYNC_W-1:0]  sync_s;
	logic               en_s;
	logic               sup_s;
	logic [NCH-1:0]     oc_s;
	logic [NCH-1:0]     severe_s;
	logic [NCH-1:0]     imb_s;
	logic [NCH-1:0]     uv_s;
	logic [NCH-1:0]     ov_s;
	logic [NCH-1:0]     below_s;
	logic [NTEMP-1:0]   trip_s;
	logic [NTEMP-1:0]   above_rst_s;
	logic [NTEMP-1:0]   shut_s;
	logic               clr;

	logic [OC_W-1:0]    oc_cnt_q [NCH];
	logic [IMB_W-1:0]   imb_cnt_q [NCH];
	logic [THERM_W-1:0] therm_cnt_q;
	logic [NCH-1:0]     oc_fault_q;
	logic [NCH-1:0]     severe_q;
	logic [NCH-1:0]     imb_q;
	logic [NCH-1:0]     uv_q;
	logic [NCH-1:0]     ov_q;
	logic [NCH-1:0]     ls_q;
	logic               therm_q;
	logic               hyst_q;
	logic               hyst_d;
	logic               alert_q;
	logic [NTEMP-1:0]   hot;
	logic               any_hot;
	logic [NCH-1:0]     shut_d;
	logic [NCH-1:0]     shut_q;
	logic [NCH-1:0]     ok_q;
	logic [NCH-1:0]     tri_q;
	logic [NCH-1:0][PCT_W-1:0] pct_q;
	rfs_run_e           run_q;

	// load percentage, clamped at full scale
	function automatic logic [PCT_W-1:0] rfs_pct(input logic [MON_W-1:0] mv);
		logic [PROD_W-1:0] prod;
		logic [PROD_W-1:0] quot;
		prod = {{PCT_W{1'b0}}, mv} * {{MON_W{1'b0}}, TEL_FULL_PCT};
		quot = prod / {{PCT_W{1'b0}}, TEL_FULL_MV};
		if (mv >= TEL_FULL_MV) begin
			return TEL_FULL_PCT;
		end
		return quot[PCT_W-1:0];
	endfunction

	// all pin-level flags cross through one synchroniser bank
	rfs_sync #(
		.W (SYNC_W)
	) u_sync (
		.core_clk_in (core_clk_in),
		.rst_in      (rst_in),
		.async_in    ({enable_in, supply_ok_in, oc_cmp_in, severe_oc_cmp_in,
		               imbalance_cmp_in, uv_cmp_in, ov_cmp_in, below_target_cmp_in,
		               temp_trip_cmp_in, temp_above_reset_cmp_in, temp_shut_cmp_in}),
		.sync_out    (sync_s)
	);

	assign {en_s, sup_s, oc_s, severe_s, imb_s, uv_s, ov_s, below_s,
	        trip_s, above_rst_s, shut_s} = sync_s;

	// faults are held cleared for as long as enable or supply is low
	assign clr = !(en_s && sup_s);

	// run sequencing; one cycle of soft-start request on every restart
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			run_q <= RUN_OFF;
		end else begin
			case (run_q)
				RUN_OFF: begin
					if (!clr) begin
						run_q <= RUN_START;
					end
				end
				RUN_START: begin
					run_q <= clr ? RUN_OFF : RUN_ON;
				end
				default: begin
					if (clr) begin
						run_q <= RUN_OFF;
					end
				end
			endcase
		end
	end

	// overcurrent qualification timers, one per output
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			for (int i = 0; i < NCH; i++) begin
				oc_cnt_q[i] <= '0;
			end
			oc_fault_q <= '0;
		end else begin
			for (int i = 0; i < NCH; i++) begin
				if (clr || !oc_s[i]) begin
					oc_cnt_q[i] <= '0;
				end else if (oc_cnt_q[i] != OC_LAST) begin
					oc_cnt_q[i] <= oc_cnt_q[i] + 1'b1;
				end
				if (clr) begin
					oc_fault_q[i] <= 1'b0;
				end else if (oc_s[i] && oc_cnt_q[i] == OC_LAST) begin
					oc_fault_q[i] <= 1'b1;
				end
			end
		end
	end

	// imbalance timers: the window restarts whenever the mismatch goes away
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			for (int i = 0; i < NCH; i++) begin
				imb_cnt_q[i] <= '0;
			end
			imb_q <= '0;
		end else begin
			for (int i = 0; i < NCH; i++) begin
				if (clr || !imb_s[i]) begin
					imb_cnt_q[i] <= '0;
				end else if (imb_cnt_q[i] != IMB_LAST) begin
					imb_cnt_q[i] <= imb_cnt_q[i] + 1'b1;
				end
				if (clr) begin
					imb_q[i] <= 1'b0;
				end else if (imb_s[i] && imb_cnt_q[i] == IMB_LAST) begin
					imb_q[i] <= 1'b1;
				end
			end
		end
	end

	// immediate faults: severe overcurrent, undervoltage, overvoltage
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			severe_q <= '0;
			uv_q     <= '0;
			ov_q     <= '0;
		end else if (clr) begin
			severe_q <= '0;
			uv_q     <= '0;
			ov_q     <= '0;
		end else begin
			severe_q <= severe_q | severe_s;
			uv_q     <= uv_q | uv_s;
			ov_q     <= ov_q | ov_s;
		end
	end

	// overvoltage crowbar: low side pulls down, lets go below target, re-arms
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			ls_q <= '0;
		end else begin
			for (int i = 0; i < NCH; i++) begin
				if (clr) begin
					ls_q[i] <= 1'b0;
				end else if (ov_s[i]) begin
					ls_q[i] <= 1'b1;
				end else if (below_s[i]) begin
					ls_q[i] <= 1'b0;
				end
			end
		end
	end

	// warning hysteresis shared by both pins: tripped level holds until both recover
	always_comb begin
		hyst_d = hyst_q;
		if (|trip_s) begin
			hyst_d = 1'b1;
		end else if (&above_rst_s) begin
			hyst_d = 1'b0;
		end
	end

	// the pin counts as hot against whichever level the hysteresis selects
	always_comb begin
		for (int p = 0; p < NTEMP; p++) begin
			hot[p] = hyst_q ? !above_rst_s[p] : trip_s[p];
		end
		any_hot = |hot;
	end

	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			hyst_q  <= 1'b0;
			alert_q <= 1'b0;
		end else begin
			hyst_q  <= hyst_d;
			alert_q <= (|oc_s) || hyst_d;
		end
	end

	// up/down counter so short cool spells only delay a thermal fault
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			therm_cnt_q <= '0;
			therm_q     <= 1'b0;
		end else begin
			if (clr) begin
				therm_cnt_q <= '0;
			end else if (any_hot && therm_cnt_q != THERM_TOP) begin
				therm_cnt_q <= therm_cnt_q + 1'b1;
			end else if (!any_hot && therm_cnt_q != '0) begin
				therm_cnt_q <= therm_cnt_q - 1'b1;
			end
			if (clr) begin
				therm_q <= 1'b0;
			end else if ((|shut_s) || (any_hot && therm_cnt_q == THERM_LAST)) begin
				therm_q <= 1'b1;
			end
		end
	end

	// shutdown combines own faults, the partner's overcurrent flags and thermal
	always_comb begin
		for (int i = 0; i < NCH; i++) begin
			shut_d[i] = oc_fault_q[i] | severe_q[i] | imb_q[i] | uv_q[i] | ov_q[i]
			          | oc_fault_q[NCH-1-i] | severe_q[NCH-1-i]
			          | therm_q;
		end
	end

	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			shut_q <= '0;
			ok_q   <= '0;
			tri_q  <= {NCH{1'b1}};
		end else begin
			shut_q <= shut_d;
			for (int i = 0; i < NCH; i++) begin
				ok_q[i]  <= (run_q == RUN_ON) && !clr && !shut_d[i];
				tri_q[i] <= (shut_d[i] || run_q != RUN_ON) && !ls_q[i];
			end
		end
	end

	// telemetry sampled every cycle
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			pct_q <= '0;
		end else begin
			for (int i = 0; i < NCH; i++) begin
				pct_q[i] <= rfs_pct(monitor_mv_in[i]);
			end
		end
	end

	// open drain: the pin only ever pulls low
	assign thermal_alert_n_out    = 1'b0;
	assign thermal_alert_oe_out   = alert_q;
	assign output_ok_out          = ok_q;
	assign chan_tristate_out      = tri_q;
	assign low_side_on_out        = ls_q;
	assign shutdown_out           = shut_q;
	assign soft_start_out         = (run_q == RUN_START);
	assign overcurrent_fault_out  = oc_fault_q;
	assign severe_overcurrent_out = severe_q;
	assign imbalance_fault_out    = imb_q;
	assign uv_fault_out           = uv_q;
	assign ov_fault_out           = ov_q;
	assign thermal_fault_out      = therm_q;
	assign load_pct_out           = pct_q;

	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (rst_in);

	property p_alert_on_temp;
		(|trip_s) |=> thermal_alert_oe_out;
	endproperty
	a_alert_on_temp: assert property (p_alert_on_temp) else $error("no alert on trip");

	property p_alert_release;
		hyst_q && !(&above_rst_s) && !(|trip_s) |=> hyst_q && thermal_alert_oe_out;
	endproperty
	a_alert_release: assert property (p_alert_release) else $error("early release");

	property p_therm_count;
		!clr && any_hot && therm_cnt_q < THERM_TOP |=> therm_cnt_q == $past(therm_cnt_q) + 1'b1;
	endproperty
	a_therm_count: assert property (p_therm_count) else $error("thermal count stuck");

	property p_therm_both;
		!clr && (|shut_s) ##1 !clr |=> &shutdown_out;
	endproperty
	a_therm_both: assert property (p_therm_both) else $error("thermal not global");

	property p_clear;
		clr |=> !(|output_ok_out) && !(|oc_fault_q) && !therm_q && !(|ov_q);
	endproperty
	a_clear: assert property (p_clear) else $error("fault survived clear");

	property p_restart;
		$fell(clr) && run_q == RUN_OFF |=> soft_start_out;
	endproperty
	a_restart: assert property (p_restart) else $error("no soft-start");

	for (genvar c = 0; c < NCH; c++) begin : g_chk
		property p_oc_alert;
			$rose(oc_s[c]) |=> thermal_alert_oe_out;
		endproperty
		a_oc_alert: assert property (p_oc_alert) else $error("oc alert late");

		property p_oc_timer;
			$rose(oc_fault_q[c]) |-> $past(oc_cnt_q[c]) == OC_LAST && $past(oc_s[c]);
		endproperty
		a_oc_timer: assert property (p_oc_timer) else $error("oc fault early");

		property p_oc_shut;
			oc_fault_q[c] && !clr |=> shutdown_out[c] && !output_ok_out[c];
		endproperty
		a_oc_shut: assert property (p_oc_shut) else $error("oc not shut");

		property p_oc_cross;
			oc_fault_q[c] && !clr |=> shutdown_out[NCH-1-c];
		endproperty
		a_oc_cross: assert property (p_oc_cross) else $error("oc cross missing");

		property p_oc_reset;
			!oc_s[c] |=> oc_cnt_q[c] == '0;
		endproperty
		a_oc_reset: assert property (p_oc_reset) else $error("oc timer kept");

		property p_severe;
			severe_s[c] && !clr ##1 !clr |=> shutdown_out[c] && !output_ok_out[c];
		endproperty
		a_severe: assert property (p_severe) else $error("severe not shut");

		property p_severe_cross;
			severe_s[c] && !clr ##1 !clr |=> shutdown_out[NCH-1-c];
		endproperty
		a_severe_cross: assert property (p_severe_cross) else $error("severe cross");

		property p_tel_clamp;
			monitor_mv_in[c] >= TEL_FULL_MV |=> load_pct_out[c] == TEL_FULL_PCT;
		endproperty
		a_tel_clamp: assert property (p_tel_clamp) else $error("telemetry clamp");

		property p_imb;
			imb_s[c] && !clr && imb_cnt_q[c] == IMB_LAST |=> imbalance_fault_out[c];
		endproperty
		a_imb: assert property (p_imb) else $error("imbalance missed");

		property p_uv;
			uv_s[c] && !ov_s[c] && !ls_q[c] && !clr ##1 !clr && !ls_q[c]
				|=> !output_ok_out[c] && chan_tristate_out[c];
		endproperty
		a_uv: assert property (p_uv) else $error("uv action missing");

		property p_ov;
			ov_s[c] && !clr |=> low_side_on_out[c] ##1 !output_ok_out[c];
		endproperty
		a_ov: assert property (p_ov) else $error("ov action missing");

		property p_ov_release;
			ls_q[c] && below_s[c] && !ov_s[c] |=> !low_side_on_out[c];
		endproperty
		a_ov_release: assert property (p_ov_release) else $error("low side stuck");

		c_oc_fault: cover property ($rose(oc_fault_q[c]));
		c_ov_cycle: cover property ($fell(ls_q[c]) ##[1:50] $rose(ls_q[c]));
	end

	c_therm_fault: cover property ($rose(therm_q) && !(|shut_s));
	c_release: cover property ($fell(hyst_q));

endmodule
`default_nettype wire

// ---- src/rfs_pkg.sv ----
// rfs_pkg: constants shared by the regulator fault supervisor and its synchroniser.
// assumes a single 100 MHz supervisor clock; every count below derives from it.
package rfs_pkg;

	// clock
	localparam int unsigned CLK_HZ = 100_000_000;
	localparam int unsigned CLK_NS = 1_000_000_000 / CLK_HZ;

	// structure
	localparam int unsigned NCH    = 2;
	localparam int unsigned NTEMP  = 2;
	localparam int unsigned SYNC_W = 2 + 6 * NCH + 3 * NTEMP;

	// protection windows, in their own units
	localparam int unsigned ALERT_MAX_NS  = 2000;
	localparam int unsigned OC_MIN_NS     = 7500;
	localparam int unsigned OC_MAX_NS     = 11000;
	localparam int unsigned CROSS_MAX_NS  = 10000;
	localparam int unsigned IMB_MS        = 1;
	localparam int unsigned THERM_MIN_US  = 100;

	// derived cycle counts: least times round up
	localparam int unsigned OC_CYC    = (OC_MIN_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned IMB_CYC   = (IMB_MS * 1_000_000 + CLK_NS - 1) / CLK_NS;
	localparam int unsigned THERM_CYC = (THERM_MIN_US * 1000 + CLK_NS - 1) / CLK_NS;
	localparam int unsigned ALERT_CYC = ALERT_MAX_NS / CLK_NS;
	localparam int unsigned CROSS_CYC = CROSS_MAX_NS / CLK_NS;

	// counter widths
	localparam int unsigned OC_W    = 10;
	localparam int unsigned IMB_W   = 17;
	localparam int unsigned THERM_W = 14;

	// telemetry: monitor voltage in millivolts, load in percent
	localparam int unsigned MON_W  = 11;
	localparam int unsigned PCT_W  = 7;
	localparam int unsigned PROD_W = MON_W + PCT_W;
	localparam logic [MON_W-1:0] TEL_FULL_MV  = 11'h4b0;
	localparam logic [PCT_W-1:0] TEL_FULL_PCT = 7'h64;

	// run sequencing
	typedef enum logic [1:0] {
		RUN_OFF,
		RUN_START,
		RUN_ON
	} rfs_run_e;

endpackage

// ---- src/rfs_sync.sv ----
// rfs_sync: two-stage synchroniser for a bundle of independent level flags.
// assumes each bit is a slow level; multi-bit words must not pass through here.
`timescale 1ns/1ps
`default_nettype none
module rfs_sync #(
	parameter int unsigned W = 1
) (
	// clock and reset
	input  wire logic         core_clk_in,
	input  wire logic         rst_in,
	// flags
	input  wire logic [W-1:0] async_in,
	output var  logic [W-1:0] sync_out
);
	logic [W-1:0] meta_q;

	// first stage feeds only the second stage
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			meta_q   <= '0;
			sync_out <= '0;
		end else begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule
`default_nettype wire

// ---- testbench/rfs_host_model.sv ----
// rfs_host_model: host processor side of the alert line and the power-good pins.
// assumes the supervisor drives the alert pin open-drain; the board pull-up sets idle high.
`timescale 1ns/1ps
`default_nettype none
module rfs_host_model (
	// from the supervisor
	input  wire logic                    alert_n_in,
	input  wire logic                    alert_oe_in,
	input  wire logic [rfs_pkg::NCH-1:0] output_ok_in,
	// resolved line and host reaction
	output wire logic                    alert_line_out,
	output var  logic                    throttle_out
);
	import rfs_pkg::*;
	// released line floats to the pull-up level, never the last driven value
	assign alert_line_out = alert_oe_in ? alert_n_in : 1'b1;
	// host throttles while the line is low or any output is not good
	always_comb throttle_out = ~alert_line_out | ~(&output_ok_in);
endmodule
`default_nettype wire

// ---- testbench/tb_regulator_fault_supervisor.sv ----
// tb_regulator_fault_supervisor: directed scenarios for rfs_supervisor.
// assumes shortened imbalance and thermal counts; the imbalance and thermal expectations use them.
`timescale 1ns/1ps
`default_nettype none
module tb_regulator_fault_supervisor;
	import rfs_pkg::*;
	localparam int unsigned IMB_T   = 20;
	localparam int unsigned THERM_T = 24;
	logic                         core_clk_in = 0, rst_in = 1, enable_in = 0, supply_ok_in = 0;
	logic [NCH-1:0]               oc = 0, sev = 0, imb = 0, uv = 0, ov = 0, bt = 0;
	logic [NTEMP-1:0]             trip = 0, arst = 2'h3, shut = 0;
	logic [NCH-1:0][MON_W-1:0]    mv = '0;
	logic                         alert_n, alert_oe, ss, tf, thr;
	logic [NCH-1:0]               ok, tri_s, ls, sd, ocf, sevf, imbf, uvf, ovf;
	logic [NCH-1:0][PCT_W-1:0]    pct;
	wire logic                    alert_line;
	int                           fails = 0, n_compared = 0;

	always #5 core_clk_in = ~core_clk_in;

	rfs_supervisor #(.IMB_CYC(IMB_T), .THERM_CYC(THERM_T)) DUT (
		.core_clk_in(core_clk_in), .rst_in(rst_in), .enable_in(enable_in),
		.supply_ok_in(supply_ok_in), .oc_cmp_in(oc), .severe_oc_cmp_in(sev),
		.imbalance_cmp_in(imb), .uv_cmp_in(uv), .ov_cmp_in(ov), .below_target_cmp_in(bt),
		.temp_trip_cmp_in(trip), .temp_above_reset_cmp_in(arst), .temp_shut_cmp_in(shut),
		.monitor_mv_in(mv), .thermal_alert_n_out(alert_n), .thermal_alert_oe_out(alert_oe),
		.output_ok_out(ok), .chan_tristate_out(tri_s), .low_side_on_out(ls),
		.shutdown_out(sd), .soft_start_out(ss), .overcurrent_fault_out(ocf),
		.severe_overcurrent_out(sevf), .imbalance_fault_out(imbf), .uv_fault_out(uvf),
		.ov_fault_out(ovf), .thermal_fault_out(tf), .load_pct_out(pct));

	rfs_host_model host (.alert_n_in(alert_n), .alert_oe_in(alert_oe), .output_ok_in(ok),
		.alert_line_out(alert_line), .throttle_out(thr));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge core_clk_in);
		#1;
	endtask

	task automatic stop_test();
		$display("compared=%0d fails=%0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	// a wait that ran out of cycles ends the run at once
	task automatic bound(input int n, input int lim);
		if (n >= lim) begin
			fails++;
			$display("ERROR t=%0t wait=%h lim=%h", $time, n, lim);
			stop_test();
		end
	endtask

	task automatic start_run();
		int n;
		@(posedge core_clk_in) begin
			enable_in <= 1;
			supply_ok_in <= 1;
		end
		for (n = 0; n < 12 && ss !== 1'b1; n++) tick(1);
		bound(n, 12);
		tick(2);
		chk(ok, 2'h3);
	endtask

	task automatic restart(input bit by_supply);
		@(posedge core_clk_in) begin
			if (by_supply) supply_ok_in <= 0;
			else enable_in <= 0;
		end
		tick(5);
		chk({ocf, sevf, imbf, uvf, ovf, tf}, 0);
		start_run();
	endtask

	task automatic t_overcurrent();
		int n;
		@(posedge core_clk_in) oc[0] <= 1;
		for (n = 0; n < 300 && alert_line !== 1'b0; n++) tick(1);
		bound(n, 300);
		chk(n <= ALERT_CYC, 1);
		tick(100);
		@(posedge core_clk_in) oc[0] <= 0;
		for (n = 0; n < 20 && alert_line !== 1'b1; n++) tick(1);
		bound(n, 20);
		chk(ocf, 0);
		// a cleared timer must take the full window again
		@(posedge core_clk_in) oc[0] <= 1;
		for (n = 0; n < 1200 && ocf[0] !== 1'b1; n++) tick(1);
		bound(n, 1200);
		chk(n >= OC_MIN_NS / CLK_NS && n <= OC_MAX_NS / CLK_NS, 1);
		for (n = 0; n < 1100 && sd !== 2'h3; n++) tick(1);
		bound(n, 1100);
		chk(n <= CROSS_CYC, 1);
		tick(2);
		chk({ok, tri_s[0]}, 3'h1);
		@(posedge core_clk_in) oc[0] <= 0;
		restart(0);
	endtask

	task automatic t_severe();
		int n;
		@(posedge core_clk_in) sev[1] <= 1;
		for (n = 0; n < 20 && sevf[1] !== 1'b1; n++) tick(1);
		bound(n, 20);
		chk(n <= 4, 1);
		for (n = 0; n < 1100 && sd !== 2'h3; n++) tick(1);
		bound(n, 1100);
		chk(n <= CROSS_CYC, 1);
		tick(2);
		chk({ok[1], tri_s[1]}, 2'h1);
		@(posedge core_clk_in) sev[1] <= 0;
		restart(1);
	endtask

	task automatic t_volt_imb();
		int n;
		@(posedge core_clk_in) uv[0] <= 1;
		tick(6);
		chk({uvf, ok, tri_s[0], sd}, 7'h35);
		@(posedge core_clk_in) uv[0] <= 0;
		restart(0);
		@(posedge core_clk_in) ov[1] <= 1;
		tick(5);
		chk({ovf[1], ok[1], ls[1], tri_s[1]}, 4'ha);
		@(posedge core_clk_in) ov[1] <= 0;
		tick(5);
		chk(ls[1], 1);
		@(posedge core_clk_in) bt[1] <= 1;
		tick(5);
		chk({ls[1], tri_s[1]}, 2'h1);
		@(posedge core_clk_in) ov[1] <= 1;
		tick(5);
		chk(ls[1], 1);
		@(posedge core_clk_in) begin
			ov[1] <= 0;
			bt[1] <= 0;
		end
		restart(0);
		@(posedge core_clk_in) imb[1] <= 1;
		for (n = 0; n < 100 && imbf[1] !== 1'b1; n++) tick(1);
		bound(n, 100);
		chk(n >= IMB_T && n <= IMB_T + 4, 1);
		tick(3);
		chk({ok, imbf[0]}, 3'h2);
		@(posedge core_clk_in) imb[1] <= 0;
		restart(1);
	endtask

	task automatic t_thermal();
		int n;
		@(posedge core_clk_in) begin
			trip[0] <= 1;
			arst[0] <= 0;
		end
		for (n = 0; n < 10 && alert_line !== 1'b0; n++) tick(1);
		bound(n, 10);
		chk({thr, alert_n}, 2'h2);
		@(posedge core_clk_in) trip[0] <= 0;
		tick(3);
		chk(alert_line, 0);
		@(posedge core_clk_in) arst <= 2'h1;
		tick(3);
		chk(alert_line, 0);
		@(posedge core_clk_in) arst <= 2'h3;
		for (n = 0; n < 10 && alert_line !== 1'b1; n++) tick(1);
		bound(n, 10);
		chk(thr, 0);
		tick(8);
		@(posedge core_clk_in) begin
			trip[0] <= 1;
			arst[0] <= 0;
		end
		tick(10);
		chk({tf, alert_line}, 2'h0);
		for (n = 0; n < 60 && tf !== 1'b1; n++) tick(1);
		bound(n, 60);
		tick(2);
		chk({sd, ok, tri_s}, 6'h33);
		@(posedge core_clk_in) begin
			trip[0] <= 0;
			arst[0] <= 1;
		end
		restart(0);
		@(posedge core_clk_in) shut[1] <= 1;
		tick(4);
		chk(tf, 1);
		tick(2);
		chk({sd, ok, tri_s}, 6'h33);
		@(posedge core_clk_in) shut[1] <= 0;
		restart(1);
	endtask

	task automatic t_telemetry();
		logic [MON_W-1:0] v[5] = '{11'h258, 11'h4b0, 11'h5dc, 11'h000, 11'h00c};
		logic [PCT_W-1:0] e[5] = '{7'h32, 7'h64, 7'h64, 7'h00, 7'h01};
		for (int i = 0; i < 5; i++) begin
			@(posedge core_clk_in) mv <= {v[i], v[(i + 1) % 5]};
			tick(3);
			chk(pct, {e[i], e[(i + 1) % 5]});
		end
	endtask

	initial begin
		tick(3);
		chk({tri_s, ok, sd}, 6'h30);
		tick(3);
		@(posedge core_clk_in) rst_in <= 0;
		start_run();
		t_overcurrent();
		t_severe();
		t_volt_imb();
		t_thermal();
		t_telemetry();
		stop_test();
	end
endmodule
`default_nettype wire
